// *** front_panel_pkg.sv ***
`default_nettype none
package front_panel_pkg;
    // Clock rate and the human-scale times derived from it.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned HOLD_MS = 3000;
    localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned HALF_MS = 500;
    localparam int unsigned HALF_CYC = HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned GAP_MS = 2000;
    localparam int unsigned GAP_TICKS = GAP_MS / HALF_MS;
    localparam int unsigned DEB_MS = 10;
    localparam int unsigned DEB_CYC = DEB_MS * (CLK_HZ / 1000);
    // Flash counts for each fault.
    localparam logic [2:0] CODE_ID_EMPTY = 3'h2;
    localparam logic [2:0] CODE_ID_CORRUPT = 3'h3;
    localparam logic [2:0] CODE_ID_TEXT = 3'h4;
    localparam logic [2:0] CODE_ID_MISSING = 3'h5;
    // Register byte offsets.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_STATE = 5'h0c;
    // Status and mask bit positions.
    localparam int unsigned ST_TOGGLE = 0;
    localparam int unsigned ST_ERASE = 1;
    localparam int unsigned ST_FW = 2;
    localparam int unsigned ST_APP = 3;
    localparam int unsigned ST_FAULT = 4;
    localparam int unsigned ST_W = 5;
    // Control bit 0 locks out the panel buttons.
    localparam int unsigned CTRL_LOCK = 0;
    localparam logic [0:0] CTRL_RST = 1'h0;
    localparam logic [4:0] MASK_RST = 5'h00;
    // Lamp colours as {red, green, blue}.
    localparam logic [2:0] LAMP_GREEN = 3'h2;
    localparam logic [2:0] LAMP_RED = 3'h4;
    localparam logic [2:0] LAMP_WHITE = 3'h7;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Phases of the flash sequencer.
    typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} flash_e;
    // Status inputs from the rest of the controller.
    typedef struct packed {
        logic bootDone;
        logic powerGood;
        logic selfTestPass;
        logic ioForcing;
        logic doIoMode;
        logic loadActive;
        logic loadFail;
        logic [2:0] loadFailCount;
        logic idEmpty;
        logic idCorrupt;
        logic idTextBad;
        logic idMissing;
        logic rtcError;
        logic ioCfgError;
        logic ladderError;
        logic netIdError;
        logic netDupError;
        logic netNoResp;
        logic firmwarePresent;
        logic defaultProgramFile;
    } panel_in_s;
    // Lamp drives.
    typedef struct packed {
        logic powerLamp;
        logic healthLamp;
        logic runLamp;
        logic [2:0] moduleStateLamp;
        logic [2:0] networkStateLamp;
    } lamps_s;
endpackage
`default_nettype wire

// *** front_panel_status_indicator.sv ***
`default_nettype none
module front_panel_status_indicator #(
    parameter int unsigned HOLD_CYC = front_panel_pkg::HOLD_CYC,
    parameter int unsigned HALF_CYC = front_panel_pkg::HALF_CYC,
    parameter int unsigned DEB_CYC = front_panel_pkg::DEB_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loadButton,
    input wire logic runStopButton,
    input wire front_panel_pkg::panel_in_s panelIn,
    output var front_panel_pkg::lamps_s lamps,
    output var logic runMode,
    output var logic eraseAll,
    output var logic firmwareLoad,
    output var logic appLoad,
    output var logic irq,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Whole state of the block; button index 1 is load, index 0 is run/stop.
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] btn;
        logic [1:0][31:0] debCnt;
        logic [1:0] combo;
        logic [31:0] holdCnt;
        logic fired;
        logic runMode;
        logic eraseAll;
        logic fwLoad;
        logic appLoad;
        logic [31:0] tickCnt;
        logic blink;
        front_panel_pkg::flash_e fl;
        logic [2:0] flashLeft;
        logic [2:0] gapLeft;
        logic [2:0] flashCode;
        front_panel_pkg::lamps_s lamps;
        logic awHeld;
        logic wHeld;
        logic [4:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [0:0] ctrl;
        logic [4:0] status;
        logic [4:0] mask;
    } state_s;

    state_s st; // Registered state.
    state_s next_st; // Next state.
    logic tick; // Half-second strobe.
    logic [2:0] diagCode; // Flash count wanted now, zero for none.
    logic [1:0] pressed; // Debounced buttons while the panel is live.

    // Half-second strobe drives both the 1 Hz blink and the fault flashes.
    assign tick = st.tickCnt == 32'(HALF_CYC - 1);

    // A load failure shows its own count; otherwise the lowest fault code wins.
    always_comb begin
        if (panelIn.loadFail) begin
            diagCode = panelIn.loadFailCount;
        end else if (panelIn.idEmpty) begin
            diagCode = front_panel_pkg::CODE_ID_EMPTY;
        end else if (panelIn.idCorrupt) begin
            diagCode = front_panel_pkg::CODE_ID_CORRUPT;
        end else if (panelIn.idTextBad) begin
            diagCode = front_panel_pkg::CODE_ID_TEXT;
        end else if (panelIn.idMissing) begin
            diagCode = front_panel_pkg::CODE_ID_MISSING;
        end else begin
            diagCode = 3'h0;
        end
    end

    // Buttons count only after boot and while software has not locked them.
    assign pressed = (panelIn.bootDone && !st.ctrl[front_panel_pkg::CTRL_LOCK]) ? st.btn : 2'h0;

    // Ready outputs follow the holding flags and the response-valid flags directly.
    assign s_axi_awready = !st.awHeld && !st.bvalid;
    assign s_axi_wready = !st.wHeld && !st.bvalid;
    assign s_axi_arready = !st.rvalid;

    // Next-state logic for the whole block.
    always_comb begin
        logic [4:0] ev;
        logic [4:0] clr;
        logic [31:0] rd;
        ev = 5'h0;
        clr = 5'h0;
        rd = 32'h0;
        next_st = st;
        // Two-stage synchroniser for the button pins.
        next_st.sync1 = {loadButton, runStopButton};
        next_st.sync2 = st.sync1;
        // A button level is accepted once it has been steady for the debounce time.
        for (int i = 0; i < 2; i++) begin
            if (st.sync2[i] == st.btn[i]) begin
                next_st.debCnt[i] = 32'h0;
            end else if (st.debCnt[i] == 32'(DEB_CYC - 1)) begin
                next_st.btn[i] = st.sync2[i];
                next_st.debCnt[i] = 32'h0;
            end else begin
                next_st.debCnt[i] = st.debCnt[i] + 32'h1;
            end
        end
        // Action pulses last one cycle.
        next_st.eraseAll = 1'b0;
        next_st.fwLoad = 1'b0;
        next_st.appLoad = 1'b0;
        // Hold timer: any change of the button pair restarts it, one action per hold.
        next_st.combo = pressed;
        if (pressed != st.combo || pressed == 2'h0) begin
            next_st.holdCnt = 32'h0;
            next_st.fired = 1'b0;
        end else if (!st.fired) begin
            if (st.holdCnt == 32'(HOLD_CYC - 1)) begin
                next_st.fired = 1'b1;
                if (pressed == 2'h3) begin
                    next_st.eraseAll = 1'b1;
                    ev[front_panel_pkg::ST_ERASE] = 1'b1;
                end else if (pressed == 2'h1) begin
                    next_st.runMode = !st.runMode;
                    ev[front_panel_pkg::ST_TOGGLE] = 1'b1;
                end else if (panelIn.firmwarePresent) begin
                    next_st.fwLoad = 1'b1;
                    ev[front_panel_pkg::ST_FW] = 1'b1;
                end else if (panelIn.defaultProgramFile) begin
                    next_st.appLoad = 1'b1;
                    ev[front_panel_pkg::ST_APP] = 1'b1;
                end
            end else begin
                next_st.holdCnt = st.holdCnt + 32'h1;
            end
        end
        // Half-second base: the blink flips each tick, giving 1 Hz.
        next_st.tickCnt = tick ? 32'h0 : st.tickCnt + 32'h1;
        if (tick) begin
            next_st.blink = !st.blink;
        end
        // A new fault is reported once when it appears.
        next_st.flashCode = diagCode;
        ev[front_panel_pkg::ST_FAULT] = diagCode != 3'h0 && st.flashCode == 3'h0;
        // Flash sequencer: equal on and off halves, then the dark gap.
        unique case (st.fl)
            front_panel_pkg::FL_IDLE: begin
                if (tick && diagCode != 3'h0) begin
                    next_st.fl = front_panel_pkg::FL_ON;
                    next_st.flashLeft = diagCode;
                end
            end
            front_panel_pkg::FL_ON: begin
                if (tick) begin
                    next_st.fl = front_panel_pkg::FL_OFF;
                end
            end
            front_panel_pkg::FL_OFF: begin
                if (tick && st.flashLeft > 3'h1) begin
                    next_st.fl = front_panel_pkg::FL_ON;
                    next_st.flashLeft = st.flashLeft - 3'h1;
                end else if (tick) begin
                    next_st.fl = front_panel_pkg::FL_GAP;
                    next_st.gapLeft = 3'(front_panel_pkg::GAP_TICKS);
                end
            end
            front_panel_pkg::FL_GAP: begin
                if (tick && st.gapLeft > 3'h1) begin
                    next_st.gapLeft = st.gapLeft - 3'h1;
                end else if (tick) begin
                    next_st.fl = front_panel_pkg::FL_ON;
                    next_st.flashLeft = diagCode;
                end
            end
        endcase
        // A cleared fault stops the pattern at once.
        if (diagCode == 3'h0) begin
            next_st.fl = front_panel_pkg::FL_IDLE;
        end
        // Health and run lamps: failure, or a fault while not loading, flashes both together; loading alternates.
        next_st.lamps.powerLamp = panelIn.powerGood;
        if (panelIn.loadFail || (!panelIn.loadActive && diagCode != 3'h0)) begin
            next_st.lamps.healthLamp = st.fl == front_panel_pkg::FL_ON;
            next_st.lamps.runLamp = st.fl == front_panel_pkg::FL_ON;
        end else if (panelIn.loadActive) begin
            next_st.lamps.healthLamp = st.blink;
            next_st.lamps.runLamp = !st.blink;
        end else begin
            next_st.lamps.healthLamp = panelIn.selfTestPass && (!panelIn.ioForcing || st.blink);
            next_st.lamps.runLamp = panelIn.doIoMode ? st.blink : st.runMode;
        end
        // Module lamp: clock or configuration errors outrank ladder errors.
        if (panelIn.rtcError || panelIn.ioCfgError) begin
            next_st.lamps.moduleStateLamp = front_panel_pkg::LAMP_RED;
        end else if (panelIn.ladderError) begin
            next_st.lamps.moduleStateLamp = front_panel_pkg::LAMP_WHITE;
        end else begin
            next_st.lamps.moduleStateLamp = front_panel_pkg::LAMP_GREEN;
        end
        // Network lamp: any network error turns it red.
        if (panelIn.netIdError || panelIn.netDupError || panelIn.netNoResp) begin
            next_st.lamps.networkStateLamp = front_panel_pkg::LAMP_RED;
        end else begin
            next_st.lamps.networkStateLamp = front_panel_pkg::LAMP_GREEN;
        end
        // Write channels are captured in either order; the write happens once both are held.
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.awHeld && st.wHeld) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = front_panel_pkg::RESP_OKAY;
            case (st.awAddr)
                front_panel_pkg::OFS_CTRL: begin
                    if (st.wStrb[0]) begin
                        next_st.ctrl = st.wData[0:0];
                    end
                end
                front_panel_pkg::OFS_MASK: begin
                    if (st.wStrb[0]) begin
                        next_st.mask = st.wData[4:0];
                    end
                end
                front_panel_pkg::OFS_STATUS, front_panel_pkg::OFS_STATE: begin
                    // Read-only registers ignore writes.
                end
                default: begin
                    next_st.bresp = front_panel_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address; reading status clears it.
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = front_panel_pkg::RESP_OKAY;
            case (s_axi_araddr)
                front_panel_pkg::OFS_CTRL: rd = 32'(st.ctrl);
                front_panel_pkg::OFS_STATUS: begin
                    rd = 32'(st.status);
                    clr = 5'h1f;
                end
                front_panel_pkg::OFS_MASK: rd = 32'(st.mask);
                front_panel_pkg::OFS_STATE: rd = 32'({st.flashCode, st.fl, st.runMode});
                default: next_st.rresp = front_panel_pkg::RESP_SLVERR;
            endcase
            next_st.rdata = rd;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // An event in the clearing cycle survives the clear.
        next_st.status = (st.status & ~clr) | ev;
    end

    // Single state register with synchronous reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrl <= front_panel_pkg::CTRL_RST;
            st.mask <= front_panel_pkg::MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign lamps = st.lamps;
    assign runMode = st.runMode;
    assign eraseAll = st.eraseAll;
    assign firmwareLoad = st.fwLoad;
    assign appLoad = st.appLoad;
    assign irq = |(st.status & st.mask);
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // Checks on the panel behaviour.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_toggle_source: assert property ($changed(st.runMode) |-> $past(st.combo) == 2'h1
        && $past(st.holdCnt) == 32'(HOLD_CYC - 1)) else $error("Run mode changed without full hold.");
    chk_erase_source: assert property (st.eraseAll |-> $past(st.combo) == 2'h3
        && $past(panelIn.bootDone)) else $error("Erase without both buttons after boot.");
    chk_gap_entry: assert property (st.fl == front_panel_pkg::FL_OFF && tick && st.flashLeft == 3'h1
        && diagCode != 3'h0 |=> st.fl == front_panel_pkg::FL_GAP && st.gapLeft == 3'h4)
        else $error("Gap not entered after last flash.");
    chk_code_empty: assert property (!panelIn.loadFail && panelIn.idEmpty
        |=> st.flashCode == 3'h2) else $error("Empty identifier code wrong.");
    chk_code_text: assert property (!panelIn.loadFail && !panelIn.idEmpty && !panelIn.idCorrupt
        && panelIn.idTextBad |=> st.flashCode == 3'h4) else $error("Text file code wrong.");
    chk_code_missing: assert property (!panelIn.loadFail && panelIn.idMissing && !panelIn.idEmpty
        && !panelIn.idCorrupt && !panelIn.idTextBad |=> st.flashCode == 3'h5) else $error("Missing code wrong.");
    chk_load_alternate: assert property (panelIn.loadActive && !panelIn.loadFail
        |=> lamps.healthLamp != lamps.runLamp) else $error("Load lamps not alternating.");
    chk_module_red: assert property (panelIn.rtcError
        |=> lamps.moduleStateLamp == front_panel_pkg::LAMP_RED) else $error("Module lamp not red.");
    chk_network_red: assert property (panelIn.netDupError
        |=> lamps.networkStateLamp == front_panel_pkg::LAMP_RED) else $error("Network lamp not red.");
    chk_health_off: assert property (!panelIn.selfTestPass && !panelIn.loadActive && diagCode == 3'h0
        |=> !lamps.healthLamp) else $error("Health lamp lit after failed test.");
    chk_app_choice: assert property (st.appLoad |-> !$past(panelIn.firmwarePresent)
        && $past(panelIn.defaultProgramFile)) else $error("Application load chosen wrongly.");
    chk_hold_restart: assert property (st.combo != $past(st.combo)
        |-> st.holdCnt == 32'h0) else $error("Hold timer kept after change.");
    chk_flash_half: assert property (st.fl == front_panel_pkg::FL_ON && tick && diagCode != 3'h0
        |=> st.fl == front_panel_pkg::FL_OFF) else $error("Flash on time wrong.");
    cov_erase: cover property (st.eraseAll);
    cov_toggle: cover property ($changed(st.runMode));
    cov_gap: cover property (st.fl == front_panel_pkg::FL_GAP);
    cov_fw_load: cover property (st.fwLoad);
endmodule
`default_nettype wire

// *** front_panel_operator.sv ***
`default_nettype none
// A person at the panel: presses buttons for a chosen time, with contact bounce.
module front_panel_operator (
    input wire logic clk,
    output logic loadButton,
    output logic runStopButton
);
    timeunit 1ns;
    timeprecision 1ps;
    // Buttons rest released.
    initial begin
        loadButton = 1'b0;
        runStopButton = 1'b0;
    end
    // Presses, bounces open for one cycle, then holds for the given cycles and releases.
    task automatic press(input logic ld, input logic rs, input int cycles);
        @(posedge clk);
        loadButton <= ld;
        runStopButton <= rs;
        @(posedge clk);
        loadButton <= 1'b0;
        runStopButton <= 1'b0;
        @(posedge clk);
        loadButton <= ld;
        runStopButton <= rs;
        repeat (cycles) @(posedge clk);
        loadButton <= 1'b0;
        runStopButton <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** front_panel_status_indicator_tb_top.sv ***
`default_nettype none
// Compares a seen value with the expected one and counts both.
`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module front_panel_status_indicator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    logic clk, rst_n, loadButton, runStopButton, runMode, eraseAll, firmwareLoad, appLoad, irq, prevRun;
    front_panel_pkg::panel_in_s panelIn, base, v;
    front_panel_pkg::lamps_s lamps;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fails, numChecks, eraseCnt, fwCnt, appCnt, toggleCnt, hiH, hiR, rise, same, code;
    // Short counts keep the run brief.
    front_panel_status_indicator #(.HOLD_CYC(40), .HALF_CYC(HALF), .DEB_CYC(3)) i_dut (
        .clk, .rst_n, .loadButton, .runStopButton, .panelIn, .lamps, .runMode, .eraseAll, .firmwareLoad,
        .appLoad, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    front_panel_operator i_op (.clk, .loadButton, .runStopButton);
    // The 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Counts pulses and run mode changes.
    always @(posedge clk) begin
        eraseCnt += (eraseAll === 1'b1);
        fwCnt += (firmwareLoad === 1'b1);
        appCnt += (appLoad === 1'b1);
        if (rst_n === 1'b1) toggleCnt += (runMode !== prevRun);
        prevRun = runMode;
    end
    // Ends the run with the verdict.
    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One register write; the master releases each channel when it is taken.
    task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
        bit aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 0;
        while (!b) begin
            @(negedge clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid & s_axi_bready;
            rs = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask
    // One register read; data and response land in rd and rs.
    task automatic axiRead(input logic [4:0] a);
        bit ar, r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 0;
        while (!r) begin
            @(negedge clk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid & s_axi_rready;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
    endtask
    // Reads a register and checks its word and an OKAY response.
    task automatic chkReg(input string nm, input logic [4:0] a, input logic [31:0] d);
        axiRead(a);
        `CHK(nm, d, rd)
        `CHK(nm, front_panel_pkg::RESP_OKAY, rs)
    endtask
    // Applies status inputs and lets the lamps follow.
    task automatic apply(input front_panel_pkg::panel_in_s x);
        @(posedge clk);
        panelIn <= x;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // Slack after a press, then a settled sampling point.
    task automatic settle;
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
    // Samples both lamps for n cycles, starting at the current falling edge.
    task automatic watch(input int n);
        logic prev;
        prev = 1'b0;
        hiH = 0;
        hiR = 0;
        rise = 0;
        same = 0;
        repeat (n) begin
            hiH += (lamps.healthLamp === 1'b1);
            hiR += (lamps.runLamp === 1'b1);
            rise += (lamps.healthLamp === 1'b1 && prev !== 1'b1);
            same += (lamps.healthLamp === lamps.runLamp);
            prev = lamps.healthLamp;
            @(negedge clk);
        end
    endtask
    // Waits for the health lamp to light after a dark spell.
    task automatic waitRise;
        int k;
        k = 0;
        while (lamps.healthLamp !== 1'b0 && k < 400) begin @(negedge clk); k++; end
        while (lamps.healthLamp !== 1'b1 && k < 800) begin @(negedge clk); k++; end
    endtask
    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    // Main sequence.
    initial begin
        base = '0;
        base.bootDone = 1'b1;
        base.powerGood = 1'b1;
        base.selfTestPass = 1'b1;
        panelIn = base;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("runLamp", 1'b0, lamps.runLamp)
        `CHK("healthLamp", 1'b1, lamps.healthLamp)
        `CHK("powerLamp", 1'b1, lamps.powerLamp)
        chkReg("ctrl", front_panel_pkg::OFS_CTRL, 32'h0);
        chkReg("mask", front_panel_pkg::OFS_MASK, 32'h0);
        axiRead(5'h10);
        `CHK("unmapped", front_panel_pkg::RESP_SLVERR, rs)
        // Run toggle with the interrupt masked, then an early release.
        i_op.press(1'b0, 1'b1, 60);
        settle();
        `CHK("toggles", 1, toggleCnt)
        `CHK("runLamp", 1'b1, lamps.runLamp)
        `CHK("irq", 1'b0, irq)
        chkReg("status", front_panel_pkg::OFS_STATUS, 32'h1);
        chkReg("status", front_panel_pkg::OFS_STATUS, 32'h0);
        i_op.press(1'b0, 1'b1, 20);
        settle();
        `CHK("toggles", 1, toggleCnt)
        // Erase with the interrupt unmasked.
        axiWrite(front_panel_pkg::OFS_MASK, 32'h1f);
        `CHK("bresp", front_panel_pkg::RESP_OKAY, rs)
        i_op.press(1'b1, 1'b1, 60);
        settle();
        `CHK("erase", 1, eraseCnt)
        `CHK("toggles", 1, toggleCnt)
        `CHK("irq", 1'b1, irq)
        chkReg("status", front_panel_pkg::OFS_STATUS, 32'h2);
        `CHK("irq", 1'b0, irq)
        // Load button: firmware first, else application, else nothing.
        for (int i = 0; i < 3; i++) begin
            v = base;
            v.firmwarePresent = (i == 0);
            v.defaultProgramFile = (i != 2);
            apply(v);
            i_op.press(1'b1, 1'b0, 60);
            settle();
            `CHK("fwLoads", 1, fwCnt)
            `CHK("appLoads", int'(i > 0), appCnt)
        end
        // Locked buttons and an unbooted unit ignore a hold.
        axiWrite(front_panel_pkg::OFS_CTRL, 32'h1);
        i_op.press(1'b0, 1'b1, 60);
        axiWrite(front_panel_pkg::OFS_CTRL, 32'h0);
        v = base;
        v.bootDone = 1'b0;
        apply(v);
        i_op.press(1'b0, 1'b1, 60);
        settle();
        `CHK("toggles", 1, toggleCnt)
        // Module and network lamp colours.
        for (int i = 0; i < 7; i++) begin
            v = base;
            case (i)
                1: v.rtcError = 1'b1;
                2: v.ioCfgError = 1'b1;
                3: v.ladderError = 1'b1;
                4: v.netIdError = 1'b1;
                5: v.netDupError = 1'b1;
                6: v.netNoResp = 1'b1;
                default: ;
            endcase
            apply(v);
            `CHK("moduleLamp", (i == 1 || i == 2) ? front_panel_pkg::LAMP_RED : (i == 3) ? front_panel_pkg::LAMP_WHITE :
                front_panel_pkg::LAMP_GREEN, lamps.moduleStateLamp)
            `CHK("networkLamp", (i > 3) ? front_panel_pkg::LAMP_RED : front_panel_pkg::LAMP_GREEN,
                lamps.networkStateLamp)
        end
        v = base;
        v.selfTestPass = 1'b0;
        apply(v);
        `CHK("healthLamp", 1'b0, lamps.healthLamp)
        v = base;
        v.ioForcing = 1'b1;
        v.doIoMode = 1'b1;
        apply(v);
        watch(4 * HALF);
        `CHK("healthOn", 2 * HALF, hiH)
        `CHK("runOn", 2 * HALF, hiR)
        // Fault codes and a failed load: one full period from a flash.
        for (int i = 0; i < 5; i++) begin
            apply(base);
            v = base;
            code = (i == 4) ? 3 : i + 2;
            case (i)
                0: v.idEmpty = 1'b1;
                1: v.idCorrupt = 1'b1;
                2: v.idTextBad = 1'b1;
                3: v.idMissing = 1'b1;
                default: begin
                    v.loadFail = 1'b1;
                    v.loadFailCount = 3'h3;
                end
            endcase
            apply(v);
            waitRise();
            watch((2 * code + 4) * HALF);
            `CHK("flashes", code, rise)
            `CHK("litCycles", code * HALF, hiH)
            `CHK("together", (2 * code + 4) * HALF, same)
            `CHK("repeat", 1'b1, lamps.healthLamp)
        end
        v = base;
        v.loadActive = 1'b1;
        apply(v);
        watch(4 * HALF);
        `CHK("alternate", 0, same)
        `CHK("healthOn", 2 * HALF, hiH)
        chkReg("status", front_panel_pkg::OFS_STATUS, 32'h1c);
        conclude();
    end
endmodule
`default_nettype wire
